// >>> bench/reg_checker.sv
/*
  reg_checker: apb and coupling properties of reg_gear.
  bound to every reg_gear instance, sees only its ports.
*/
`timescale 1ns/1ps
module reg_checker
  import reg_pkg::*;
#(
  parameter int SPD_WIN = 16
) (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        halt_release_i,
  input wire logic [31:0] pos_setpoint_o,
  input wire logic [31:0] speed_setpoint_o,
  input wire logic        coupled_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic setup;
  logic ctl_wr;
  assign setup  = psel_i && !penable_i;
  assign ctl_wr = psel_i && penable_i && pwrite_i && paddr_i == REG_CTRL_OFS && pwdata_i[3];
  // =====================================================
  // properties
  property p_setup_ready;
    setup |=> pready_o;
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_unmapped;
    setup && (paddr_i > REG_SPEED_OFS || paddr_i[1:0] != 2'h0) |=> pslverr_o && prdata_o == 32'h0;
  endproperty
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  property p_couple;
    ctl_wr && pwdata_i[2:0] == 3'h5 |-> ##[1:3] coupled_o;
  endproperty
  property p_decouple;
    ctl_wr && pwdata_i[2:0] == 3'h1 |-> ##[1:3] !coupled_o;
  endproperty
  property p_speed_zero;
    !coupled_o [*2] |-> speed_setpoint_o == 32'h0;
  endproperty
  property p_pos_hold;
    !coupled_o [*3] |-> $stable(pos_setpoint_o);
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_couple: assert property (p_couple) else $error("sync couple late");
  a_decouple: assert property (p_decouple) else $error("sync decouple late");
  a_speed_zero: assert property (p_speed_zero) else $error("speed while idle");
  a_pos_hold: assert property (p_pos_hold) else $error("position moved idle");
  c_couple: cover property (ctl_wr && pwdata_i[2:0] == 3'h5);
  c_unmapped: cover property (setup && paddr_i > REG_SPEED_OFS);
  c_halt: cover property ($fell(halt_release_i) && coupled_o);
endmodule : reg_checker

bind reg_gear reg_checker #(.SPD_WIN(SPD_WIN)) i_chk (
  .mclk_i           (mclk_i),
  .sys_rst_i        (sys_rst_i),
  .psel_i           (psel_i),
  .penable_i        (penable_i),
  .pwrite_i         (pwrite_i),
  .paddr_i          (paddr_i),
  .pwdata_i         (pwdata_i),
  .prdata_o         (prdata_o),
  .pready_o         (pready_o),
  .pslverr_o        (pslverr_o),
  .halt_release_i   (halt_release_i),
  .pos_setpoint_o   (pos_setpoint_o),
  .speed_setpoint_o (speed_setpoint_o),
  .coupled_o        (coupled_o)
);

// >>> bench/reg_enc_model.sv
/*
  reg_enc_model: leading-axis encoder, quadrature or pulse/direction.
  tasks are called by the bench; tracks change after a clock edge.
*/
`timescale 1ns/1ps
module reg_enc_model (
  input  wire logic clk_i,
  output logic      a_o,
  output logic      b_o,
  output logic      idx_o
);
  int ph;
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
    idx_o = 1'b0;
    ph = 0;
  end
  // one track state, random index, then a wait
  task automatic step(input logic a, input logic b, input int gap);
    @(posedge clk_i);
    a_o <= a;
    b_o <= b;
    idx_o <= 1'($urandom_range(0, 1));
    repeat (gap) @(posedge clk_i);
  endtask : step
  // a leads b when moving forward
  task automatic quad(input int n, input int gap);
    for (int i = 0; i < 4 * (n < 0 ? -n : n); i++) begin
      ph = (ph + (n < 0 ? 3 : 1)) % 4;
      step(ph == 1 || ph == 2, ph >= 2, gap);
    end
  endtask : quad
  // b high for reverse, pulses on a
  task automatic pulse(input int n, input int gap);
    step(1'b0, n < 0, gap);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      step(1'b1, n < 0, gap);
      step(1'b0, n < 0, gap);
    end
    step(1'b0, 1'b0, gap);
    // tracks now stand low, the quadrature phase zero
    ph = 0;
  endtask : pulse
endmodule : reg_enc_model

// >>> bench/tb.sv
/*
  tb: self-checking bench for reg_gear with an encoder model.
  assumes the 100 MHz clock and synchronous reset made here.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end \
end
module tb;
  import reg_pkg::*;
  logic        clk, rst, psel, penable, pwrite, halt, use_htl, e;
  logic        pready, perr, coupled, ea, eb, ei;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q, prdata, pos, spd, p0;
  int          num_errors, checked, cyc, n, num, lines;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  reg_gear #(.SPD_WIN(16)) i_dut (.mclk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .ttl_index_i(ei),
    .ttl_a_i(ea & !use_htl), .ttl_b_i(eb & !use_htl), .htl_a_i(ea & use_htl),
    .htl_b_i(eb & use_htl), .halt_release_i(halt), .pos_setpoint_o(pos),
    .speed_setpoint_o(spd), .coupled_o(coupled));
  reg_enc_model i_enc (.clk_i(clk), .a_o(ea), .b_o(eb), .idx_o(ei));
  // =====================================================
  // tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = perr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic int gear(int n, int nu, int de, int ln);
    return n * 65536 * nu / (ln * de);
  endfunction : gear
  task automatic mv(input int n, input bit pm, input int k, input int gap);
    p0 = pos;
    if (pm) i_enc.pulse(n, gap);
    else i_enc.quad(n, gap);
    repeat (8) @(posedge clk);
    `CHK("pos", p0 + 32'(k), pos) // position in increments
  endtask : mv
  task final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      final_report;
    end
  end
  // =====================================================
  // sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, halt, use_htl} = '0;
    rst = 1'b1;
    void'($urandom(5098));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(0, REG_TTLCFG_OFS, 0);
    `CHK("ttl cfg", 32'h0400_0010, q) // line default
    apb(0, REG_HTLRAT_OFS, 0);
    `CHK("htl ratio", 32'h0001_0001, q) // ratio default
    apb(0, 8'h24, 0);
    `CHK("unmapped", 1'b1, e) // unmapped refused
    apb(1, REG_CHAN_OFS, 32'h3);
    apb(0, REG_CHAN_OFS, 0);
    `CHK("chan", 32'h0, q) // bad channel ignored
    apb(1, REG_CHAN_OFS, 32'h1);
    apb(1, REG_TTLCFG_OFS, 32'h0400_0020);
    apb(0, REG_STAT_OFS, 0);
    `CHK("cfg bad", 1'b0, q[2]) // invalid config
    apb(1, REG_TTLCFG_OFS, 32'h0400_0010);
    apb(0, REG_STAT_OFS, 0);
    `CHK("cfg ok", 1'b1, q[2]) // ttl config
    apb(1, REG_TTLRAT_OFS, 32'h0000_0001);
    apb(0, REG_TTLRAT_OFS, 0);
    `CHK("den zero", 32'h0001_0001, q) // zero refused
    apb(1, REG_TTLRAT_OFS, 32'h0002_0001); // den set while off
    apb(1, REG_CTRL_OFS, 32'h0000_000D);
    apb(0, REG_STAT_OFS, 0);
    `CHK("sync", 2'h2, q[1:0]) // sync couple
    apb(1, REG_TTLRAT_OFS, 32'h0005_FFFF);
    apb(0, REG_TTLRAT_OFS, 0);
    `CHK("live ratio", 32'h0002_FFFF, q) // live write
    for (int i = 0; i < 12; i++) begin
      lines = (i % 3 == 0) ? 32 : (i % 3 == 1) ? 1024 : 8192;
      num = int'($urandom_range(0, 8)) - 4;
      n = int'($urandom_range(0, 16)) - 8;
      apb(1, REG_TTLCFG_OFS, 32'((lines << 16) | 16'h10 | (i % 2)));
      apb(1, REG_TTLRAT_OFS, {16'h0002, 16'(num)});
      mv(n, i[0], gear(n, num, 2, lines), $urandom_range(2, 5));
    end
    use_htl <= 1'b1;
    apb(1, REG_CHAN_OFS, 32'h2);
    mv(5, 1'b0, gear(5, 1, 1, 1024), 3); // htl channel
    apb(1, REG_CHAN_OFS, 32'h0);
    mv(5, 1'b0, 0, 3); // channel off
    apb(1, REG_CHAN_OFS, 32'h1);
    use_htl <= 1'b0;
    apb(1, REG_CTRL_OFS, 32'h0000_0009);
    mv(3, 1'b0, 0, 2); // decoupled holds
    apb(1, REG_TTLCFG_OFS, 32'h0400_0010);
    apb(1, REG_TTLRAT_OFS, 32'h0002_0001);
    halt <= 1'b1;
    apb(1, REG_CTRL_OFS, 32'h0000_0303); // wrong source
    apb(0, REG_STAT_OFS, 0);
    `CHK("src", 2'h0, q[1:0]) // source four only
    apb(1, REG_CTRL_OFS, 32'h0000_0403);
    apb(0, REG_STAT_OFS, 0);
    `CHK("speed", 2'h1, q[1:0]) // speed coupled
    i_enc.quad(30, 2);
    `CHK("speed up", 1'b1, $signed(spd) > 0) // speed follows
    halt <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("halt", 1'b0, coupled) // halt decouples
    final_report;
  end
endmodule : tb

// >>> hw/reg_gear.sv
/*
  reg_gear: reference encoder input with ratio gearing to a follower setpoint.
  assumes APB master on mclk_i; encoder pins asynchronous to mclk_i.
*/
`timescale 1ns/1ps
module reg_gear
  import reg_pkg::*;
#(
  parameter int SPD_WIN = SPD_WIN_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        ttl_a_i,
  input  wire logic        ttl_b_i,
  input  wire logic        ttl_index_i,
  input  wire logic        htl_a_i,
  input  wire logic        htl_b_i,
  input  wire logic        halt_release_i,
  output logic      [31:0] pos_setpoint_o,
  output logic      [31:0] speed_setpoint_o,
  output logic             coupled_o
);
  // =====================================================
  // registers
  logic [1:0]   chan_reg;
  logic         ttl_type_reg, htl_type_reg;
  logic [3:0]   ttl_port_reg;
  logic [13:0]  ttl_lines_reg, htl_lines_reg;
  logic [15:0]  ttl_num_reg, htl_num_reg, ttl_den_reg, htl_den_reg;
  logic         ctrl_on_reg, spd_mode_reg, sync_arg_reg, cmd_reg;
  logic [3:0]   src_reg;
  reg_state_t   state_reg;
  logic [31:0]  pos_reg, speed_reg, spd_acc_reg;
  logic [3:0]   pin_meta_reg, pin_sync_reg;
  logic         a_prev_reg, b_prev_reg;
  logic         enc_ok;
  logic [47:0]  frac_reg;
  logic [31:0]  win_reg;
  logic [31:0]  rd_next;

  wire wr_en = psel_i & penable_i & pwrite_i;
  wire rd_en = psel_i & penable_i & ~pwrite_i;
  wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= REG_SPEED_OFS);
  wire cmd_wr = wr_en && (paddr_i == REG_CTRL_OFS) && pwdata_i[CTRL_CMD_BIT];

  // =====================================================
  // apb access, one wait-free access phase
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_next : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_next = SIG_EXTRA;
    case (paddr_i)
      REG_CHAN_OFS:   rd_next = {30'h0, chan_reg};
      REG_TTLCFG_OFS: rd_next = {2'h0, ttl_lines_reg, 8'h0, ttl_port_reg, 3'h0, ttl_type_reg};
      REG_TTLRAT_OFS: rd_next = {ttl_den_reg, ttl_num_reg};
      REG_HTLCFG_OFS: rd_next = {2'h0, htl_lines_reg, 15'h0, htl_type_reg};
      REG_HTLRAT_OFS: rd_next = {htl_den_reg, htl_num_reg};
      REG_CTRL_OFS:   rd_next = {20'h0, src_reg, 4'h0, 1'b0, sync_arg_reg, spd_mode_reg,
                                 ctrl_on_reg};
      REG_STAT_OFS:   rd_next = {29'h0, enc_ok, state_reg};
      REG_POS_OFS:    rd_next = pos_reg;
      REG_SPEED_OFS:  rd_next = speed_reg;
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  // =====================================================
  // configuration registers
  function automatic logic [13:0] clamp_lines(input logic [13:0] v);
    if (v < LINES_MIN) clamp_lines = LINES_MIN;
    else if (v > LINES_MAX) clamp_lines = LINES_MAX;
    else clamp_lines = v;
  endfunction : clamp_lines

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      chan_reg      <= CHAN_OFF;
      ttl_type_reg  <= 1'b0;
      htl_type_reg  <= 1'b0;
      ttl_port_reg  <= TTL_CFG_VALID;
      ttl_lines_reg <= LINES_RST;
      htl_lines_reg <= LINES_RST;
      ttl_num_reg   <= NUM_RST;
      htl_num_reg   <= NUM_RST;
      ttl_den_reg   <= DEN_RST;
      htl_den_reg   <= DEN_RST;
      ctrl_on_reg   <= 1'b0;
      spd_mode_reg  <= 1'b0;
      sync_arg_reg  <= 1'b0;
      src_reg       <= 4'h0;
    end else if (wr_en) begin
      case (paddr_i)
        REG_CHAN_OFS:
          if (pwdata_i[1:0] <= CHAN_HTL) chan_reg <= pwdata_i[1:0];
        REG_TTLCFG_OFS: begin
          ttl_type_reg  <= pwdata_i[CFG_TYPE_BIT];
          ttl_port_reg  <= pwdata_i[CFG_PORT_LSB +: 4];
          ttl_lines_reg <= clamp_lines(pwdata_i[CFG_LINES_LSB +: 14]);
        end
        REG_TTLRAT_OFS: begin
          ttl_num_reg <= pwdata_i[15:0];
          if (!ctrl_on_reg && pwdata_i[RAT_DEN_LSB +: 16] != 16'h0000)
            ttl_den_reg <= pwdata_i[RAT_DEN_LSB +: 16];
        end
        REG_HTLCFG_OFS: begin
          htl_type_reg  <= pwdata_i[CFG_TYPE_BIT];
          htl_lines_reg <= clamp_lines(pwdata_i[CFG_LINES_LSB +: 14]);
        end
        REG_HTLRAT_OFS: begin
          htl_num_reg <= pwdata_i[15:0];
          if (!ctrl_on_reg && pwdata_i[RAT_DEN_LSB +: 16] != 16'h0000)
            htl_den_reg <= pwdata_i[RAT_DEN_LSB +: 16];
        end
        REG_CTRL_OFS: begin
          ctrl_on_reg  <= pwdata_i[CTRL_ON_BIT];
          spd_mode_reg <= pwdata_i[CTRL_SPD_BIT];
          if (pwdata_i[CTRL_CMD_BIT]) sync_arg_reg <= pwdata_i[CTRL_SYNC_BIT];
          src_reg      <= pwdata_i[CTRL_SRC_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // =====================================================
  // channel selection
  wire use_htl = (chan_reg == CHAN_HTL);
  assign enc_ok = (chan_reg == CHAN_HTL) ||
                  (chan_reg == CHAN_TTL && ttl_port_reg == TTL_CFG_VALID);
  wire        sel_type  = use_htl ? htl_type_reg : ttl_type_reg;
  wire [13:0] sel_lines = use_htl ? htl_lines_reg : ttl_lines_reg;
  wire [15:0] sel_num   = use_htl ? htl_num_reg : ttl_num_reg;
  wire [15:0] sel_den   = use_htl ? htl_den_reg : ttl_den_reg;

  // =====================================================
  // input synchronisers; index pin deliberately unused
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      // every track pin passes two flops before the channel mux
      pin_meta_reg <= {htl_b_i, htl_a_i, ttl_b_i, ttl_a_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire a_now  = use_htl ? pin_sync_reg[2] : pin_sync_reg[0];
  wire b_now  = use_htl ? pin_sync_reg[3] : pin_sync_reg[1];

  // previous track levels for edge detection
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= a_now;
      b_prev_reg <= b_now;
    end
  end

  wire a_prev = a_prev_reg;
  wire b_prev = b_prev_reg;
  logic signed [1:0] step;
  always_comb begin
    step = 2'sd0;
    if (!sel_type) begin
      if (a_now != a_prev && b_now == b_prev)
        step = (a_now ^ b_now) ? 2'sd1 : -2'sd1;
      else if (b_now != b_prev && a_now == a_prev)
        step = (a_now ^ b_now) ? -2'sd1 : 2'sd1;
    end else if (a_now && !a_prev) begin
      step = b_now ? -2'sd1 : 2'sd1;
    end
  end

  // =====================================================
  // gearing: inc = step * 65536/(lines*edges) * num / den
  wire [15:0] edges_per_line = sel_type ? 16'd1 : 16'd4;
  wire [31:0] scale_den = 32'(sel_lines) * 32'(edges_per_line) * 32'(sel_den);
  wire signed [47:0] step_inc = 48'(step) * 48'(signed'(sel_num)) * 48'(INC_PER_REV);
  wire signed [47:0] frac_sum = signed'(frac_reg) + step_inc;
  wire signed [47:0] q_inc    = frac_sum / signed'(48'(scale_den));
  wire signed [47:0] r_rem    = frac_sum - q_inc * signed'(48'(scale_den));

  // control fields as they stand after a control write this cycle
  wire       ctrl_wr = wr_en && (paddr_i == REG_CTRL_OFS);
  wire       on_eff  = ctrl_wr ? pwdata_i[CTRL_ON_BIT] : ctrl_on_reg;
  wire       spd_eff = ctrl_wr ? pwdata_i[CTRL_SPD_BIT] : spd_mode_reg;
  wire [3:0] src_eff = ctrl_wr ? pwdata_i[CTRL_SRC_LSB +: 4] : src_reg;

  wire coupled = (state_reg != REG_ST_IDLE);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      frac_reg <= 48'h0;
      pos_reg  <= 32'h0;
    end else if (!enc_ok) begin
      frac_reg <= 48'h0;
    end else if (step != 2'sd0) begin
      frac_reg <= r_rem;
      pos_reg  <= pos_reg + q_inc[31:0];
    end
  end

  // =====================================================
  // speed: increments per window, smoothed
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      win_reg     <= 32'h0;
      spd_acc_reg <= 32'h0;
      speed_reg   <= 32'h0;
    end else begin
      spd_acc_reg <= (step != 2'sd0 && enc_ok) ? spd_acc_reg + q_inc[31:0] : spd_acc_reg;
      if (win_reg >= 32'(SPD_WIN - 1)) begin
        win_reg     <= 32'h0;
        spd_acc_reg <= 32'h0;
        speed_reg   <= speed_reg + 32'(signed'(spd_acc_reg - speed_reg) >>> 2);
      end else begin
        win_reg <= win_reg + 32'h1;
      end
    end
  end

  // =====================================================
  // coupling state machine
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= REG_ST_IDLE;
    end else if (!on_eff || !enc_ok) begin
      state_reg <= REG_ST_IDLE;
    end else begin
      case (state_reg)
        REG_ST_IDLE:
          if (spd_eff && halt_release_i && src_eff == SRC_DIGSLAVE)
            state_reg <= REG_ST_SPEED;
          else if (!spd_eff && cmd_wr && pwdata_i[CTRL_SYNC_BIT])
            state_reg <= REG_ST_SYNC;
        REG_ST_SPEED:
          if (!spd_eff || !halt_release_i || src_eff != SRC_DIGSLAVE)
            state_reg <= REG_ST_IDLE;
        REG_ST_SYNC:
          if (spd_eff || (cmd_wr && !pwdata_i[CTRL_SYNC_BIT]))
            state_reg <= REG_ST_IDLE;
        default:
          state_reg <= REG_ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // outputs; coupling applied at once with no ramp
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      coupled_o        <= 1'b0;
      pos_setpoint_o   <= 32'h0;
      speed_setpoint_o <= 32'h0;
    end else begin
      coupled_o        <= coupled;
      pos_setpoint_o   <= (state_reg == REG_ST_SYNC) ? pos_reg : pos_setpoint_o;
      speed_setpoint_o <= (state_reg == REG_ST_SPEED) ? speed_reg : 32'h0;
    end
  end
endmodule : reg_gear

// >>> include/reg_pkg.sv
/*
  reg_pkg: constants for the reference encoder gearing block.
  assumes a 100 MHz system clock and an APB register bus.
*/
package reg_pkg;
  // =====================================================
  // register byte offsets
  localparam logic [7:0] REG_CHAN_OFS    = 8'h00;
  localparam logic [7:0] REG_TTLCFG_OFS  = 8'h04;
  localparam logic [7:0] REG_TTLRAT_OFS  = 8'h08;
  localparam logic [7:0] REG_HTLCFG_OFS  = 8'h0C;
  localparam logic [7:0] REG_HTLRAT_OFS  = 8'h10;
  localparam logic [7:0] REG_CTRL_OFS    = 8'h14;
  localparam logic [7:0] REG_STAT_OFS    = 8'h18;
  localparam logic [7:0] REG_POS_OFS     = 8'h1C;
  localparam logic [7:0] REG_SPEED_OFS   = 8'h20;
  // =====================================================
  // field positions
  localparam int CFG_TYPE_BIT   = 0;
  localparam int CFG_PORT_LSB   = 4;
  localparam int CFG_LINES_LSB  = 16;
  localparam int RAT_DEN_LSB    = 16;
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_SPD_BIT   = 1;
  localparam int CTRL_SYNC_BIT  = 2;
  localparam int CTRL_CMD_BIT   = 3;
  localparam int CTRL_SRC_LSB   = 8;
  // =====================================================
  // codes and reset values
  localparam logic [1:0]  CHAN_OFF       = 2'h0;
  localparam logic [1:0]  CHAN_TTL       = 2'h1;
  localparam logic [1:0]  CHAN_HTL       = 2'h2;
  localparam logic [3:0]  TTL_CFG_VALID  = 4'h1;
  localparam logic [3:0]  SRC_DIGSLAVE   = 4'h4;
  localparam logic [13:0] LINES_RST      = 14'h0400;
  localparam logic [13:0] LINES_MIN      = 14'h0020;
  localparam logic [13:0] LINES_MAX      = 14'h2000;
  localparam logic [15:0] NUM_RST        = 16'h0001;
  localparam logic [15:0] DEN_RST        = 16'h0001;
  localparam int          INC_PER_REV    = 65536;
  // speed sample window: 1 ms
  localparam int          SPD_WIN_US     = 1000;
  localparam int          SPD_WIN_CYC    = SPD_WIN_US * 100;
  localparam logic [31:0] SIG_EXTRA      = 32'h0000_0000;
  typedef enum logic [1:0] {
    REG_ST_IDLE  = 2'b00,
    REG_ST_SPEED = 2'b01,
    REG_ST_SYNC  = 2'b10
  } reg_state_t;
endpackage : reg_pkg
